// ==== dv/csp_chan_pins_chk.sv ====
`timescale 1ns/1ps
module csp_chan_pins_chk #(parameter int unsigned NUM_CH = 2) (
  // Clock, reset, inputs
  input wire logic                              clk_i,
  input wire logic                              srst_i,
  input wire csp_pkg::csp_cfg_type  [NUM_CH-1:0] cfg_i,
  input wire csp_pkg::csp_stat_type [NUM_CH-1:0] stat_i,
  input wire logic [NUM_CH-1:0]                 partner_align_status_in_i,
  input wire logic [NUM_CH-1:0]                 channel_powerdown_n_i,
  // Outputs
  input wire csp_pkg::csp_diff_type [NUM_CH-1:0] hs_serial_tx_out_o,
  input wire logic [NUM_CH-1:0]                 rx_signal_loss_flag_o,
  input wire logic [NUM_CH-1:0]                 rx_signal_loss_flag_oe_o,
  input wire logic [NUM_CH-1:0]                 local_align_status_out_o,
  input wire logic [NUM_CH-1:0]                 channel_pd_o,
  input wire logic [NUM_CH-1:0]                 partner_aligned_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Channel 0 only; both channels share one body
  wire up0  = channel_powerdown_n_i[0] && !cfg_i[0].reg_powerdown;
  wire los0 = up0 && cfg_i[0].los_enable
              && cfg_i[0].los_select == csp_pkg::LOSSEL_LOS;
  AST_RST_SER:
    assert property (disable iff (1'b0) srst_i |=>
      hs_serial_tx_out_o[0] == 2'b01) else $error("serial not zero");
  AST_RST_FLAG:
    assert property (disable iff (1'b0) srst_i |=>
      {rx_signal_loss_flag_o[0], rx_signal_loss_flag_oe_o[0]} == 2'b01)
      else $error("flag not low in reset");
  AST_PD_FLOAT:
    assert property (!up0 |=> !rx_signal_loss_flag_oe_o[0])
      else $error("flag driven while down");
  AST_PD_STATE:
    assert property (1 |=> channel_pd_o[0] == $past(!up0))
      else $error("power-down state wrong");
  AST_ALIGN_OUT:
    assert property (1 |=> local_align_status_out_o[0] ==
      $past(stat_i[0].tx_lanes_aligned && cfg_i[0].gp10g_mode))
      else $error("align out wrong");
  AST_PART_GATE:
    assert property (1 |=> partner_aligned_o[0] ==
      $past(partner_align_status_in_i[0] && cfg_i[0].gp10g_mode))
      else $error("partner status wrong");
  AST_LOSS_SET:
    assert property ((los0 && stat_i[0].below_assert) [*3] |=>
      rx_signal_loss_flag_o[0]) else $error("loss not flagged");
  AST_LOSS_HOLD:
    assert property ((los0 && !stat_i[0].below_assert
      && !stat_i[0].above_deassert) [*3] |=>
      rx_signal_loss_flag_o[0] == $past(rx_signal_loss_flag_o[0], 2))
      else $error("flag not held");
  AST_ROUTE:
    assert property ((up0 && cfg_i[0].los_select == csp_pkg::LOSSEL_AUX)
      [*2] |=> rx_signal_loss_flag_o[0] == $past(stat_i[0].aux_status))
      else $error("routed status wrong");
endmodule // csp_chan_pins_chk
////////////////////////////////////////////////////////////////////////////
bind csp_chan_pins csp_chan_pins_chk #(.NUM_CH(NUM_CH)) u_chk (
  .clk_i, .srst_i, .cfg_i, .stat_i, .partner_align_status_in_i,
  .channel_powerdown_n_i, .hs_serial_tx_out_o, .rx_signal_loss_flag_o,
  .rx_signal_loss_flag_oe_o, .local_align_status_out_o, .channel_pd_o,
  .partner_aligned_o);

// ==== dv/csp_chan_pins_test.sv ====
`timescale 1ns/1ps
module csp_chan_pins_test;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  csp_pkg::csp_cfg_type  [1:0] cfg = '0;
  csp_pkg::csp_stat_type [1:0] stat = '0;
  csp_pkg::csp_diff_type [1:0] hs_o;
  csp_pkg::csp_diff_type [7:0] ls_o;
  logic [1:0] hs_d = '0, pd_n = 2'b11, want = '0, part, flag, oe, al, pd, pal;
  logic [7:0] ls_d = '0;
  int n_mismatch = 0;
  int n_compared = 0;
  always #50 clk_i = ~clk_i;
  csp_partner u_partner (.clk_i(clk_i), .aligned_i(want), .status_o(part));
  csp_chan_pins u_dut (.clk_i(clk_i), .srst_i(srst_i), .cfg_i(cfg),
    .stat_i(stat), .hs_tx_data_i(hs_d), .ls_tx_data_i(ls_d),
    .partner_align_status_in_i(part), .channel_powerdown_n_i(pd_n),
    .hs_serial_tx_out_o(hs_o), .ls_lane_outputs_o(ls_o),
    .rx_signal_loss_flag_o(flag), .rx_signal_loss_flag_oe_o(oe),
    .local_align_status_out_o(al), .channel_pd_o(pd),
    .partner_aligned_o(pal));
  ////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wrap_up;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Detector and data busy during reset; outputs must ignore them
  task automatic t_reset;
    cfg = {2{5'h10}}; stat = {2{4'h4}}; hs_d = 2'b11; ls_d = 8'hff;
    pd_n = 2'b10;
    cyc(3);
    chk(hs_o, 16'h0005);
    chk(ls_o, 16'h5555);
    chk({flag, oe}, 16'h0003);
    cyc(3); srst_i = 1'b0; pd_n = 2'b11; hs_d = 2'b01;
  endtask
  task automatic t_loss;
    cyc(3);
    chk({flag, hs_o}, 16'h0036);
    chk(ls_o, 16'haaaa);
    stat = '0; cyc(3); chk(flag, 16'h0003);
    stat = {2{4'h8}}; cyc(3); chk(flag, 16'h0000);
    stat = {2{4'h4}}; cfg = '0; cyc(3); chk(flag, 16'h0000);
  endtask
  // Every select code, two status patterns, partner gated by mode
  task automatic t_route;
    logic [3:0] pat;
    for (int k = 0; k < 2; k++) begin
      for (int s = 0; s < 4; s++) begin
        want = k ? 2'b00 : 2'b11; stat = {2{k ? 4'h9 : 4'ha}};
        cfg = {2{5'h14 | 5'(s)}}; cyc(3);
        pat = k ? 4'h8 : 4'h6;
        chk(flag, {14'h0, {2{pat[s]}}});
        chk({al, pal}, k ? 16'h0 : 16'hf);
      end
    end
    want = 2'b11; stat = {2{4'ha}}; cfg = {2{5'h10}}; cyc(3);
    chk({al, pal}, 16'h0000);
  endtask
  task automatic t_pd;
    hs_d = 2'b11; pd_n = 2'b10; cyc(3);
    chk({oe, pd, hs_o}, 16'h0099);
    chk(ls_o, 16'haa55);
    pd_n = 2'b11;
    cyc(1);
    // Controller follows power-up with a reset of the channel
    srst_i = 1'b1;
    cyc(2);
    chk({flag, oe, pd, hs_o}, 16'h00f5);
    srst_i = 1'b0;
    cyc(3); chk({oe, pd}, 16'h000c);
    cfg[1] = 5'h18; cyc(3); chk({oe, pd}, 16'h0006);
  endtask
  initial begin
    t_reset(); t_loss(); t_route(); t_pd();
    wrap_up();
  end
  // Whole run is some 60 cycles
  initial begin
    #100000;
    n_mismatch++;
    wrap_up();
  end
endmodule // csp_chan_pins_test

// ==== dv/csp_partner.sv ====
`timescale 1ns/1ps
module csp_partner (
  // Clock and request
  input  wire logic       clk_i,
  input  wire logic [1:0] aligned_i,
  // Alignment status pin
  output logic      [1:0] status_o
);
  // Registered: changes just after the edge, like a real far end
  always_ff @(posedge clk_i) begin
    status_o <= aligned_i;
  end
endmodule // csp_partner

// ==== logic/csp_chan_pins.sv ====
`timescale 1ns/1ps
// Functional notes
// [R1] In reset, high-speed and low-speed serial outputs drive differential zero.
// [R2] Loss flag is 1 on loss, 0 on signal, only when enabled.
// [R3] In reset, the loss flag output is driven low.
// [R4] Loss flag pin is undriven while channel powered down, pin or register. Here it is driven low during reset even when powered down.
// [R5] Configuration may route other status to the loss flag pin, live.
// [R6] Partner alignment input is 1 when aligned; used only in 10G mode.
// [R7] Local alignment output shows transmit lanes aligned; meaningful in 10G.
// [R8] Powerdown input low powers channel down; high resumes operation.
// [R9] Controller should issue datapath reset after powerdown release.
// [R10] Between thresholds the loss flag holds its last value.
module csp_chan_pins #(
  parameter int unsigned NUM_CH   = csp_pkg::NUM_CH,
  parameter int unsigned LS_LANES = csp_pkg::LS_LANES
) (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          srst_i,
  // Management configuration and core status
  input  wire csp_pkg::csp_cfg_type  [NUM_CH-1:0] cfg_i,
  input  wire csp_pkg::csp_stat_type [NUM_CH-1:0] stat_i,
  // Datapath serial data from the core
  input  wire logic [NUM_CH-1:0]             hs_tx_data_i,
  input  wire logic [NUM_CH*LS_LANES-1:0]    ls_tx_data_i,
  // Link partner pins
  input  wire logic [NUM_CH-1:0]             partner_align_status_in_i,
  input  wire logic [NUM_CH-1:0]             channel_powerdown_n_i,
  output csp_pkg::csp_diff_type [NUM_CH-1:0] hs_serial_tx_out_o,
  output csp_pkg::csp_diff_type [NUM_CH*LS_LANES-1:0] ls_lane_outputs_o,
  output logic [NUM_CH-1:0]                  rx_signal_loss_flag_o,
  output logic [NUM_CH-1:0]                  rx_signal_loss_flag_oe_o,
  output logic [NUM_CH-1:0]                  local_align_status_out_o,
  // Core side status
  output logic [NUM_CH-1:0]                  channel_pd_o,
  output logic [NUM_CH-1:0]                  partner_aligned_o
);

  ////////////////////////////////////////////////////////////////////////
  // Parameter checks; zero widths leave no pins to serve
  if (NUM_CH < 1) begin : g_bad_ch
    $error("csp_chan_pins: NUM_CH must be nonzero");
  end
  if (LS_LANES < 1) begin : g_bad_ln
    $error("csp_chan_pins: LS_LANES must be nonzero");
  end

  ////////////////////////////////////////////////////////////////////////
  // Loss flag source selection, shared by every channel
  function automatic logic pick_status(
    input logic [1:0] sel,
    input logic       loss,
    input logic       align,
    input logic       partner,
    input logic       aux
  );
    logic r;
    // Default keeps an unknown select from leaving r unset
    r = loss;
    unique case (sel)
      csp_pkg::LOSSEL_LOS: begin
        r = loss;
      end
      csp_pkg::LOSSEL_ALIGN: begin
        r = align;
      end
      csp_pkg::LOSSEL_PART: begin
        r = partner;
      end
      csp_pkg::LOSSEL_AUX: begin
        r = aux;
      end
    endcase
    return r;
  endfunction

  function automatic csp_pkg::csp_diff_type to_diff(input logic bit_v);
    csp_pkg::csp_diff_type d;
    d.p = bit_v;
    d.n = ~bit_v;
    return d;
  endfunction

  // Flat lane index: a channel's lanes sit side by side
  function automatic int unsigned lane_idx(
    input int unsigned chan,
    input int unsigned lane
  );
    return chan * LS_LANES + lane;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Per channel pin logic
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic                  loss_w;
      logic                  pd_w;
      logic                  align_gate_w;
      logic                  flag_w;
      logic                  flag_d;
      logic                  flag_q;
      logic                  oe_d;
      logic                  oe_q;
      logic                  lao_d;
      logic                  lao_q;
      logic                  pd_q;
      logic                  pal_q;
      csp_pkg::csp_diff_type hs_d;
      csp_pkg::csp_diff_type hs_q;

      csp_los_hyst u_los (
        .clk_i            (clk_i),
        .srst_i           (srst_i),
        .below_assert_i   (stat_i[ch].below_assert),
        .above_deassert_i (stat_i[ch].above_deassert),
        .enable_i         (cfg_i[ch].los_enable),               // [R2]
        .loss_o           (loss_w)
      );

      // Pin or register power-down, either suffices
      assign pd_w = !channel_powerdown_n_i[ch]
                    || cfg_i[ch].reg_powerdown;                  // [R8]
      // Partner status ignored outside 10G serdes mode
      assign align_gate_w = partner_align_status_in_i[ch]
                            && cfg_i[ch].gp10g_mode;              // [R6]
      assign flag_w = pick_status(cfg_i[ch].los_select, loss_w,
                                  stat_i[ch].tx_lanes_aligned,
                                  align_gate_w,
                                  stat_i[ch].aux_status);        // [R5]

      //////////////////////////////////////////////////////////////////
      // Next register values
      // A parked flag holds low; the pin shows the selected status from its first driven cycle
      assign flag_d = pd_w ? 1'b0 : flag_w;                      // [R2]
      assign oe_d   = !pd_w;                                     // [R4]
      // Only meaningful in 10G mode; held low elsewhere
      assign lao_d  = stat_i[ch].tx_lanes_aligned
                      && cfg_i[ch].gp10g_mode;                   // [R7]
      // Powered down channel parks at zero too
      assign hs_d   = to_diff(hs_tx_data_i[ch] && !pd_w);        // [R8]

      //////////////////////////////////////////////////////////////////
      // One register per block keeps each reset value easy to audit
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          flag_q <= csp_pkg::RST_LOSS_FLAG;                      // [R3]
        end else begin
          flag_q <= flag_d;
        end
      end

      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          oe_q <= csp_pkg::RST_FLAG_OE;                          // [R3]
        end else begin
          oe_q <= oe_d;
        end
      end

      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          lao_q <= csp_pkg::RST_ALIGN_OUT;
        end else begin
          lao_q <= lao_d;
        end
      end

      // Power-down and partner status back to the core
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          pd_q <= csp_pkg::RST_PD_ACTIVE;
        end else begin
          pd_q <= pd_w;                                          // [R8]
        end
      end

      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          pal_q <= csp_pkg::RST_PART_ALIGN;
        end else begin
          pal_q <= align_gate_w;                                 // [R6]
        end
      end

      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          hs_q <= to_diff(csp_pkg::RST_SER_ZERO);                // [R1]
        end else begin
          hs_q <= hs_d;
        end
      end

      //////////////////////////////////////////////////////////////////
      // Outputs come straight from the flops
      assign rx_signal_loss_flag_o[ch]    = flag_q;
      assign rx_signal_loss_flag_oe_o[ch] = oe_q;
      assign local_align_status_out_o[ch] = lao_q;
      assign channel_pd_o[ch]             = pd_q;
      assign partner_aligned_o[ch]        = pal_q;
      assign hs_serial_tx_out_o[ch]       = hs_q;

      genvar ln;
      for (ln = 0; ln < LS_LANES; ln++) begin : g_ln
        csp_pkg::csp_diff_type ls_d;
        csp_pkg::csp_diff_type ls_q;
        // Powered down lanes park at zero as well
        assign ls_d = to_diff(ls_tx_data_i[lane_idx(ch, ln)] && !pd_w);
        always_ff @(posedge clk_i) begin
          if (srst_i) begin
            ls_q <= to_diff(csp_pkg::RST_SER_ZERO);              // [R1]
          end else begin
            ls_q <= ls_d;                                        // [R8]
          end
        end
        assign ls_lane_outputs_o[lane_idx(ch, ln)] = ls_q;
      end
    end
  endgenerate

  // Datapath reset after power-up is left to the controller [R9]

endmodule // csp_chan_pins

// ==== logic/csp_los_hyst.sv ====
`timescale 1ns/1ps
// Loss detector with hysteresis band
module csp_los_hyst (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // Level comparator inputs
  input  wire logic below_assert_i,
  input  wire logic above_deassert_i,
  input  wire logic enable_i,
  // Held loss state
  output logic      loss_o
);

  logic loss_q;
  logic loss_d;

  // Between thresholds keep the last value
  assign loss_d = !enable_i       ? 1'b0 :
                  below_assert_i  ? 1'b1 :
                  above_deassert_i ? 1'b0 : loss_q;   // [R10]

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      loss_q <= csp_pkg::RST_LOSS_FLAG;
    end else begin
      loss_q <= loss_d;
    end
  end

  assign loss_o = loss_q;

endmodule // csp_los_hyst

// ==== logic/csp_pkg.sv ====
package csp_pkg;

  // Channel count and lane width
  localparam int unsigned NUM_CH      = 2;
  localparam int unsigned LS_LANES    = 4;

  // Status routing select codes for the loss indicator pin
  localparam logic [1:0] LOSSEL_LOS   = 2'h0;
  localparam logic [1:0] LOSSEL_ALIGN = 2'h1;
  localparam logic [1:0] LOSSEL_PART  = 2'h2;
  localparam logic [1:0] LOSSEL_AUX   = 2'h3;

  // Reset values
  localparam logic RST_LOSS_FLAG      = 1'b0;
  localparam logic RST_ALIGN_OUT      = 1'b0;
  localparam logic RST_SER_ZERO       = 1'b0;
  localparam logic RST_PD_ACTIVE      = 1'b1;
  localparam logic RST_FLAG_OE        = 1'b1;
  localparam logic RST_PART_ALIGN     = 1'b0;

  // Serial output pair: p and n level pair
  typedef struct packed {
    logic p;
    logic n;
  } csp_diff_type;

  // Per-channel configuration from the management block
  typedef struct packed {
    logic       los_enable;
    logic       reg_powerdown;
    logic       gp10g_mode;
    logic [1:0] los_select;
  } csp_cfg_type;

  // Per-channel detector and datapath state from the core
  typedef struct packed {
    logic       above_deassert;
    logic       below_assert;
    logic       tx_lanes_aligned;
    logic       aux_status;
  } csp_stat_type;

endpackage : csp_pkg
